// File: core/dbg_scratch_mem.sv
// Shared scratch words with two access ports and registered read data
`timescale 1ns/1ps
module dbg_scratch_mem #(
	parameter int DEPTH = 8,
	parameter int WIDTH = 32
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic a_we,
	input wire logic [$clog2(DEPTH)-1:0] a_addr,
	input wire logic [WIDTH-1:0] a_wdata,
	output logic [WIDTH-1:0] a_rdata,
	input wire logic b_we,
	input wire logic [$clog2(DEPTH)-1:0] b_addr,
	input wire logic [WIDTH-1:0] b_wdata,
	output logic [WIDTH-1:0] b_rdata
);
	logic [WIDTH-1:0] mem [DEPTH];

	// Port A wins if both write the same word
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < DEPTH; i++) mem[i] <= '0;
		end else begin
			if (b_we) mem[b_addr] <= b_wdata;
			if (a_we) mem[a_addr] <= a_wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			a_rdata <= '0;
			b_rdata <= '0;
		end else begin
			a_rdata <= mem[a_addr];
			b_rdata <= mem[b_addr];
		end
	end
endmodule // dbg_scratch_mem

// File: core/debug_state_capture_regs.sv
// Debug state capture register block
// Summary of operation
// - Debug entry captures interrupted status word
// - Status bit 7 fast, bit 6 paused
// - Status bits 4..0 mode flags, bit 5 reserved
// - Bit 10 space id, 9 entry issue, 8 read-only
// - Debug entry captures program counter at 0x11
// - Debug entry captures stack pointer at 0x12
// - Fetch thread number in low eight bits
// - Fetch register number in low five bits
// - Three-bit cause code, reset zero
// - Causing thread in 15:8, zero for host
// - Data watchpoint stores effective address
// - Resource watchpoint stores resource identifier
// - Per-thread stall mask bits stop threads outside debug
// - Scratch words shared with tile configuration space
// - Breakpoint address match raises debug interrupt
// - Four independent breakpoints at 0x30..0x33
// - Enable bit, inequality select, per-thread enables
`timescale 1ns/1ps
module debug_state_capture_regs #(
	parameter int THREADS = dbg_regs_pkg::NUM_THREADS,
	parameter int BREAKS = dbg_regs_pkg::NUM_IBREAK,
	parameter int SCRATCH = dbg_regs_pkg::NUM_SCRATCH
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	// Processor-status access from the tile
	input wire dbg_regs_pkg::reg_req_s ps_req,
	output logic [31:0] ps_rdata,
	output logic ps_rvalid,
	// Tile configuration access (JTAG path) to scratch words
	input wire logic cfg_scratch_we,
	input wire logic [2:0] cfg_scratch_addr,
	input wire logic [31:0] cfg_scratch_wdata,
	output logic [31:0] cfg_scratch_rdata,
	// Debug entry from the pipeline
	input wire dbg_regs_pkg::dbg_entry_s entry,
	// Current issue mode of the thread in debug
	input wire logic issue_mode_bit,
	// Program counter of the issuing thread
	input wire logic pc_valid,
	input wire logic [31:0] issue_pc,
	input wire logic [7:0] issue_thread,
	input wire logic in_debug_mode,
	// Breakpoint request and lowest firing index
	output logic ibreak_hit,
	output logic [1:0] ibreak_index,
	output logic [THREADS-1:0] thread_stall,
	output logic [7:0] remote_fetch_thread,
	output logic [4:0] remote_fetch_register
);
	logic [31:0] saved_status;
	logic [31:0] saved_pc;
	logic [31:0] saved_sp;
	logic [31:0] fetch_thread;
	logic [31:0] fetch_reg;
	logic [31:0] cause;
	logic [31:0] info;
	logic [31:0] stall_mask;
	logic [31:0] brk_addr [BREAKS];
	logic [31:0] brk_ctrl [BREAKS];
	logic [31:0] scratch_rdata;
	logic [31:0] next_rdata;
	logic [31:0] next_cause;
	logic [31:0] next_info;
	logic rd_scratch_q;
	logic [BREAKS-1:0] hits;

	function automatic logic hit_reg(input logic [7:0] a,
			input logic [7:0] ofs);
		return a == ofs;
	endfunction

	function automatic logic hit_range(input logic [7:0] a,
			input logic [7:0] base, input int n);
		return (a >= base) && (a < base + 8'(n));
	endfunction

	function automatic logic is_watch(input dbg_regs_pkg::cause_e c);
		return c == dbg_regs_pkg::CAUSE_DWATCH ||
			c == dbg_regs_pkg::CAUSE_RWATCH;
	endfunction

	wire logic wr = ps_req.wr;
	wire logic [7:0] addr = ps_req.addr;
	wire logic [31:0] wd = ps_req.wdata;
	wire logic sel_status = hit_reg(addr, dbg_regs_pkg::OFS_SAVED_STATUS);
	wire logic sel_pc = hit_reg(addr, dbg_regs_pkg::OFS_SAVED_PC);
	wire logic sel_sp = hit_reg(addr, dbg_regs_pkg::OFS_SAVED_SP);
	wire logic sel_fthr = hit_reg(addr, dbg_regs_pkg::OFS_FETCH_THREAD);
	wire logic sel_freg = hit_reg(addr, dbg_regs_pkg::OFS_FETCH_REG);
	wire logic sel_cause = hit_reg(addr, dbg_regs_pkg::OFS_CAUSE);
	wire logic sel_info = hit_reg(addr, dbg_regs_pkg::OFS_INFO);
	wire logic sel_stall = hit_reg(addr, dbg_regs_pkg::OFS_STALL_MASK);
	wire logic sel_scr = hit_range(addr, dbg_regs_pkg::OFS_SCRATCH,
		SCRATCH);
	wire logic sel_baddr = hit_range(addr, dbg_regs_pkg::OFS_INSTR_BREAK_ADDRESS,
		BREAKS);
	wire logic sel_bctrl = hit_range(addr, dbg_regs_pkg::OFS_IBREAK_CTRL,
		BREAKS);
	wire logic [1:0] brk_sel = addr[1:0];
	wire logic take = entry.take;

	// One physical scratch set, two access ports
	dbg_scratch_mem #(
		.DEPTH(SCRATCH),
		.WIDTH(32)
	) u_scratch (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.a_we(wr && sel_scr),
		.a_addr(addr[2:0]),
		.a_wdata(wd),
		.a_rdata(scratch_rdata),
		.b_we(cfg_scratch_we),
		.b_addr(cfg_scratch_addr),
		.b_wdata(cfg_scratch_wdata),
		.b_rdata(cfg_scratch_rdata)
	);

	genvar g;
	generate
		for (g = 0; g < BREAKS; g++) begin : g_brk
			ibreak_unit #(
				.THREADS(THREADS)
			) u_brk (
				.break_addr(brk_addr[g]),
				.ctrl(brk_ctrl[g]),
				.pc(issue_pc),
				.thread(issue_thread),
				.pc_valid(pc_valid && !in_debug_mode),
				.hit(hits[g])
			);
		end
	endgenerate

	always_comb begin
		ibreak_index = 2'h0;
		for (int i = BREAKS - 1; i >= 0; i--) begin
			if (hits[i]) ibreak_index = 2'(i);
		end
	end
	assign ibreak_hit = |hits;

	always_comb begin
		next_cause = 32'h00000000;
		next_cause[dbg_regs_pkg::CAUSE_CODE_LSB +: 3] = entry.cause;
		if (entry.cause != dbg_regs_pkg::CAUSE_HOST) begin
			next_cause[dbg_regs_pkg::CAUSE_THREAD_LSB +: 8] = entry.thread;
		end
		// Index zero for host and call
		if (entry.cause == dbg_regs_pkg::CAUSE_IBREAK ||
				is_watch(entry.cause)) begin
			next_cause[dbg_regs_pkg::CAUSE_INDEX_LSB +: 2] =
				entry.watch_index;
		end
	end

	always_comb begin
		next_info = info;
		if (is_watch(entry.cause)) begin
			next_info = entry.info;
		end
	end

	// Capture wins over a same-cycle write
	wire logic sw_wr = wr && !take;
	wire logic we_status = sw_wr && sel_status;
	wire logic we_pc = sw_wr && sel_pc;
	wire logic we_sp = sw_wr && sel_sp;
	wire logic we_cause = sw_wr && sel_cause;
	wire logic we_info = sw_wr && sel_info;
	wire logic we_fthr = wr && sel_fthr;
	wire logic we_freg = wr && sel_freg;
	wire logic we_stall = wr && sel_stall;

	// Bit 8 never stored, read live
	wire logic [31:0] next_status = dbg_regs_pkg::STATUS_RW_MASK &
		(take ? entry.status : wd);
	wire logic [31:0] next_pc = take ? entry.pc : wd;
	wire logic [31:0] next_sp = take ? entry.sp : wd;
	// Reserved cause bits masked on write
	wire logic [31:0] next_cause_word = take ? next_cause :
		wd & dbg_regs_pkg::CAUSE_MASK;
	wire logic [31:0] next_info_word = take ? next_info : wd;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			saved_status <= 32'h00000000;
		end else if (take || we_status) begin
			saved_status <= next_status;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			saved_pc <= 32'h00000000;
		end else if (take || we_pc) begin
			saved_pc <= next_pc;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			saved_sp <= 32'h00000000;
		end else if (take || we_sp) begin
			saved_sp <= next_sp;
		end
	end

	// Cause word, code resets to zero
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cause <= 32'(dbg_regs_pkg::CAUSE_RESET);
		end else if (take || we_cause) begin
			cause <= next_cause_word;
		end
	end

	// Trigger data, kept unless a watchpoint fired
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			info <= 32'h00000000;
		end else if (take || we_info) begin
			info <= next_info_word;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			fetch_thread <= 32'h00000000;
		end else if (we_fthr) begin
			fetch_thread <= wd & dbg_regs_pkg::FETCH_THREAD_MASK;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			fetch_reg <= 32'h00000000;
		end else if (we_freg) begin
			fetch_reg <= wd & dbg_regs_pkg::FETCH_REG_MASK;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			stall_mask <= 32'h00000000;
		end else if (we_stall) begin
			stall_mask <= wd & dbg_regs_pkg::STALL_MASK_MASK;
		end
	end

	// Breakpoint addresses
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < BREAKS; i++) begin
				brk_addr[i] <= 32'h00000000;
			end
		end else if (wr && sel_baddr) begin
			brk_addr[brk_sel] <= wd;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < BREAKS; i++) begin
				brk_ctrl[i] <= 32'h00000000;
			end
		end else if (wr && sel_bctrl) begin
			brk_ctrl[brk_sel] <=
				wd & dbg_regs_pkg::IBREAK_CTRL_MASK;
		end
	end

	assign thread_stall = in_debug_mode ? '0 : stall_mask[THREADS-1:0];
	assign remote_fetch_thread = fetch_thread[7:0];
	assign remote_fetch_register = fetch_reg[4:0];

	// Live issue mode copy in bit 8
	wire logic [31:0] status_view = saved_status |
		(32'(issue_mode_bit) << dbg_regs_pkg::STATUS_ISSUE_BIT);

	// Selects are one-hot, so gated words are ORed
	// Unmapped and reserved read zero
	wire logic [31:0] rd_status = {32{sel_status}} & status_view;
	wire logic [31:0] rd_pc = {32{sel_pc}} & saved_pc;
	wire logic [31:0] rd_sp = {32{sel_sp}} & saved_sp;
	wire logic [31:0] rd_fthr = {32{sel_fthr}} & fetch_thread;
	wire logic [31:0] rd_freg = {32{sel_freg}} & fetch_reg;
	wire logic [31:0] rd_cause = {32{sel_cause}} & cause;
	wire logic [31:0] rd_info = {32{sel_info}} & info;
	wire logic [31:0] rd_stall = {32{sel_stall}} & stall_mask;
	wire logic [31:0] rd_baddr = {32{sel_baddr}} & brk_addr[brk_sel];
	wire logic [31:0] rd_bctrl = {32{sel_bctrl}} & brk_ctrl[brk_sel];
	assign next_rdata = rd_status | rd_pc | rd_sp | rd_fthr | rd_freg |
		rd_cause | rd_info | rd_stall | rd_baddr | rd_bctrl;

	// Register reads answer one cycle later
	logic [31:0] rdata_q;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 32'h00000000;
		end else begin
			rdata_q <= next_rdata;
		end
	end

	// Marks a read of the scratch words
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_scratch_q <= 1'b0;
		end else begin
			rd_scratch_q <= ps_req.rd && sel_scr;
		end
	end

	// Read answer one cycle after the request
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ps_rvalid <= 1'b0;
		end else begin
			ps_rvalid <= ps_req.rd;
		end
	end

	// Scratch data comes from the memory's own register
	assign ps_rdata = rd_scratch_q ? scratch_rdata : rdata_q;
endmodule // debug_state_capture_regs

// File: core/ibreak_unit.sv
// One instruction breakpoint comparator
`timescale 1ns/1ps
module ibreak_unit #(
	parameter int THREADS = 8
) (
	input wire logic [31:0] break_addr,
	input wire logic [31:0] ctrl,
	input wire logic [31:0] pc,
	input wire logic [7:0] thread,
	input wire logic pc_valid,
	output logic hit
);
	wire logic enabled = ctrl[dbg_regs_pkg::BRK_EN_BIT];
	wire logic not_equal = ctrl[dbg_regs_pkg::BRK_NE_BIT];
	wire logic [THREADS-1:0] thr_en =
		ctrl[dbg_regs_pkg::BRK_THREAD_LSB +: THREADS];
	wire logic same = (pc == break_addr);
	wire logic thr_ok = (thread < THREADS) &&
		thr_en[thread[$clog2(THREADS)-1:0]];

	assign hit = pc_valid && enabled && thr_ok && (same ^ not_equal);
endmodule // ibreak_unit

// File: include/dbg_regs_pkg.sv
// Package for the debug state capture register block
package dbg_regs_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NUM_THREADS = 8;
	localparam int NUM_IBREAK = 4;
	localparam int NUM_SCRATCH = 8;

	// Register offsets (processor-status numbering)
	localparam logic [7:0] OFS_SAVED_STATUS = 8'h10;
	localparam logic [7:0] OFS_SAVED_PC = 8'h11;
	localparam logic [7:0] OFS_SAVED_SP = 8'h12;
	localparam logic [7:0] OFS_FETCH_THREAD = 8'h13;
	localparam logic [7:0] OFS_FETCH_REG = 8'h14;
	localparam logic [7:0] OFS_CAUSE = 8'h15;
	localparam logic [7:0] OFS_INFO = 8'h16;
	localparam logic [7:0] OFS_STALL_MASK = 8'h18;
	localparam logic [7:0] OFS_SCRATCH = 8'h20;
	localparam logic [7:0] OFS_INSTR_BREAK_ADDRESS = 8'h30;
	localparam logic [7:0] OFS_IBREAK_CTRL = 8'h40;

	// Saved status word: writable bits and read-only issue mode copy
	localparam logic [31:0] STATUS_RW_MASK = 32'h000006DF;
	localparam int STATUS_ISSUE_BIT = 8;
	localparam logic [31:0] FETCH_THREAD_MASK = 32'h000000FF;
	localparam logic [31:0] FETCH_REG_MASK = 32'h0000001F;
	localparam logic [31:0] CAUSE_MASK = 32'h0003FF07;
	localparam logic [31:0] STALL_MASK_MASK = 32'h000000FF;
	localparam logic [31:0] IBREAK_CTRL_MASK = 32'h00FF0003;

	// Cause field position and reset
	localparam int CAUSE_CODE_LSB = 0;
	localparam int CAUSE_THREAD_LSB = 8;
	localparam int CAUSE_INDEX_LSB = 16;
	localparam logic [2:0] CAUSE_RESET = 3'h0;
	localparam int BRK_EN_BIT = 0;
	localparam int BRK_NE_BIT = 1;
	localparam int BRK_THREAD_LSB = 16;

	typedef enum logic [2:0] {
		CAUSE_NONE = 3'h0,
		CAUSE_HOST = 3'h1,
		CAUSE_DEBUG_CALL_INSTRUCTION = 3'h2,
		CAUSE_IBREAK = 3'h3,
		CAUSE_DWATCH = 3'h4,
		CAUSE_RWATCH = 3'h5
	} cause_e;

	// Register access request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} reg_req_s;

	// State of the interrupted thread and the trigger, presented at entry
	typedef struct packed {
		logic take;
		cause_e cause;
		logic [7:0] thread;
		logic [1:0] watch_index;
		logic [31:0] status;
		logic [31:0] pc;
		logic [31:0] sp;
		logic [31:0] info;
	} dbg_entry_s;

endpackage

// File: verification/dbg_capture_props.sv
// Assertions on the debug state capture register ports
`timescale 1ns/1ps
module dbg_capture_props #(
	parameter int THREADS = 8
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire dbg_regs_pkg::reg_req_s ps_req,
	input wire logic [31:0] ps_rdata,
	input wire logic ps_rvalid,
	input wire dbg_regs_pkg::dbg_entry_s entry,
	input wire logic issue_mode_bit,
	input wire logic pc_valid,
	input wire logic in_debug_mode,
	input wire logic ibreak_hit,
	input wire logic [THREADS-1:0] thread_stall,
	input wire logic [7:0] remote_fetch_thread,
	input wire logic [4:0] remote_fetch_register
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_rd(a);
		ps_req.rd && ps_req.addr == a;
	endsequence
	// Capture, then read on the next cycle
	sequence s_take_rd(a);
		entry.take ##1 s_rd(a);
	endsequence
	property p_stall_debug;
		in_debug_mode |-> thread_stall == '0;
	endproperty
	a_stall_debug: assert property (p_stall_debug)
		else $error("stall mask active in debug mode");
	property p_hit_debug;
		in_debug_mode |-> !ibreak_hit;
	endproperty
	a_hit_debug: assert property (p_hit_debug)
		else $error("breakpoint hit while in debug mode");
	property p_hit_valid;
		!pc_valid |-> !ibreak_hit;
	endproperty
	a_hit_valid: assert property (p_hit_valid)
		else $error("breakpoint hit without valid pc");
	property p_cause_rsv;
		s_rd(dbg_regs_pkg::OFS_CAUSE) |=> ps_rvalid
			&& ps_rdata[31:18] == '0 && ps_rdata[7:3] == '0;
	endproperty
	a_cause_rsv: assert property (p_cause_rsv)
		else $error("cause read reserved bits set");
	property p_status_issue;
		s_rd(dbg_regs_pkg::OFS_SAVED_STATUS) |=> ps_rdata[31:11] == '0
			&& !ps_rdata[5] && ps_rdata[8] == $past(issue_mode_bit);
	endproperty
	a_status_issue: assert property (p_status_issue)
		else $error("status read bit 8 or reserved wrong");
	property p_thread_sel;
		s_rd(dbg_regs_pkg::OFS_FETCH_THREAD) |=>
			ps_rdata == {24'h0, $past(remote_fetch_thread)};
	endproperty
	a_thread_sel: assert property (p_thread_sel)
		else $error("thread select read mismatch");
	property p_reg_sel;
		s_rd(dbg_regs_pkg::OFS_FETCH_REG) |=>
			ps_rdata == {27'h0, $past(remote_fetch_register)};
	endproperty
	a_reg_sel: assert property (p_reg_sel)
		else $error("register select read mismatch");
	property p_pc_cap;
		s_take_rd(dbg_regs_pkg::OFS_SAVED_PC) |=> ps_rdata == $past(entry.pc, 2);
	endproperty
	a_pc_cap: assert property (p_pc_cap)
		else $error("saved pc not captured");
	property p_sp_cap;
		s_take_rd(dbg_regs_pkg::OFS_SAVED_SP) |=> ps_rdata == $past(entry.sp, 2);
	endproperty
	a_sp_cap: assert property (p_sp_cap)
		else $error("saved stack pointer not captured");
endmodule // dbg_capture_props
bind debug_state_capture_regs dbg_capture_props #(.THREADS(THREADS))
	u_dbg_capture_props (.*);

// File: verification/debugger_model.sv
// External debugger model on the tile configuration scratch port
`timescale 1ns/1ps
module debugger_model (
	input wire logic sys_clk,
	output logic cfg_scratch_we,
	output logic [2:0] cfg_scratch_addr,
	output logic [31:0] cfg_scratch_wdata,
	input wire logic [31:0] cfg_scratch_rdata
);
	initial begin
		cfg_scratch_we = 1'b0;
		cfg_scratch_addr = 3'h0;
		cfg_scratch_wdata = 32'h0;
	end
	task automatic cfg_write(input logic [2:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		cfg_scratch_we <= 1'b1;
		cfg_scratch_addr <= a;
		cfg_scratch_wdata <= d;
		@(posedge sys_clk);
		cfg_scratch_we <= 1'b0;
		cfg_scratch_wdata <= ~d;
	endtask
	task automatic cfg_read(input logic [2:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		cfg_scratch_addr <= a;
		@(posedge sys_clk);
		@(negedge sys_clk);
		d = cfg_scratch_rdata;
	endtask
endmodule // debugger_model

// File: verification/test_debug_state_capture_regs.sv
// Self-checking bench for the debug state capture registers
`timescale 1ns/1ps
module test_debug_state_capture_regs;
	logic sys_clk;
	logic rst_n;
	dbg_regs_pkg::reg_req_s ps_req;
	logic [31:0] ps_rdata;
	logic ps_rvalid;
	logic cfg_scratch_we;
	logic [2:0] cfg_scratch_addr;
	logic [31:0] cfg_scratch_wdata;
	logic [31:0] cfg_scratch_rdata;
	dbg_regs_pkg::dbg_entry_s entry;
	logic issue_mode_bit;
	logic pc_valid;
	logic [31:0] issue_pc;
	logic [7:0] issue_thread;
	logic in_debug_mode;
	logic ibreak_hit;
	logic [1:0] ibreak_index;
	logic [7:0] thread_stall;
	logic [7:0] remote_fetch_thread;
	logic [4:0] remote_fetch_register;
	int miscompares = 0;
	int total_checks = 0;
	logic [31:0] v;
	debug_state_capture_regs u_debug_state_capture_regs (.*);
	debugger_model u_debugger_model (.sys_clk, .cfg_scratch_we,
		.cfg_scratch_addr, .cfg_scratch_wdata, .cfg_scratch_rdata);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		ps_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge sys_clk);
		ps_req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		ps_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge sys_clk);
		ps_req.rd <= 1'b0;
		@(negedge sys_clk);
		d = (ps_rvalid === 1'b1) ? ps_rdata : 'x;
	endtask
	task automatic t_reset();
		rd(dbg_regs_pkg::OFS_CAUSE, v);
		chk(v, 32'h0);
		rd(8'h50, v);
		chk(v, 32'h0);
	endtask
	task automatic t_capture();
		logic [31:0] info;
		info = 32'h0;
		for (int c = 1; c <= 5; c++) begin
			@(posedge sys_clk);
			issue_mode_bit <= c[0];
			entry <= '{take: 1'b1, cause: dbg_regs_pkg::cause_e'(c[2:0]),
				thread: 8'h03, watch_index: 2'h2, status: 32'hFFFFFFFF,
				pc: 32'h1000 + c, sp: 32'h2000 + c, info: 32'h3000 + c};
			@(posedge sys_clk);
			entry.take <= 1'b0;
			ps_req <= '{wr: 1'b0, rd: 1'b1, addr: c[0] ? 8'h11 : 8'h12,
				wdata: 32'h0};
			if (c >= 4) info = 32'h3000 + c;
			rd(dbg_regs_pkg::OFS_SAVED_PC, v);
			chk(v, 32'h1000 + c);
			rd(dbg_regs_pkg::OFS_SAVED_SP, v);
			chk(v, 32'h2000 + c);
			rd(dbg_regs_pkg::OFS_SAVED_STATUS, v);
			chk(v, c[0] ? 32'h7DF : 32'h6DF);
			rd(dbg_regs_pkg::OFS_CAUSE, v);
			chk(v, {14'h0, ((c > 2) ? 2'h2 : 2'h0), ((c == 1) ? 8'h0 : 8'h3),
				5'h0, c[2:0]});
			rd(dbg_regs_pkg::OFS_INFO, v);
			chk(v, info);
		end
	endtask
	task automatic t_regs();
		wr(dbg_regs_pkg::OFS_SAVED_STATUS, 32'hFFFFFFFF);
		issue_mode_bit <= 1'b0;
		rd(dbg_regs_pkg::OFS_SAVED_STATUS, v);
		chk(v, 32'h000006DF);
		wr(dbg_regs_pkg::OFS_CAUSE, 32'hFFFFFFFF);
		rd(dbg_regs_pkg::OFS_CAUSE, v);
		chk(v, 32'h0003FF07);
		wr(dbg_regs_pkg::OFS_FETCH_THREAD, 32'hFFFFFFFF);
		wr(dbg_regs_pkg::OFS_FETCH_REG, 32'hFFFFFFFF);
		wr(dbg_regs_pkg::OFS_STALL_MASK, 32'hFFFFFF5A);
		rd(dbg_regs_pkg::OFS_FETCH_THREAD, v);
		chk(v, 32'hFF);
		chk({24'h0, remote_fetch_thread}, 32'hFF);
		rd(dbg_regs_pkg::OFS_FETCH_REG, v);
		chk(v, 32'h1F);
		chk({27'h0, remote_fetch_register}, 32'h1F);
		rd(dbg_regs_pkg::OFS_STALL_MASK, v);
		chk(v, 32'h5A);
		chk({24'h0, thread_stall}, 32'h5A);
		@(posedge sys_clk);
		in_debug_mode <= 1'b1;
		@(negedge sys_clk);
		chk({24'h0, thread_stall}, 32'h0);
		@(posedge sys_clk);
		in_debug_mode <= 1'b0;
	endtask
	task automatic t_scratch();
		wr(dbg_regs_pkg::OFS_SCRATCH + 8'h7, 32'hA5A50007);
		u_debugger_model.cfg_read(3'h7, v);
		chk(v, 32'hA5A50007);
		u_debugger_model.cfg_write(3'h0, 32'h5A5A0000);
		rd(dbg_regs_pkg::OFS_SCRATCH, v);
		chk(v, 32'h5A5A0000);
	endtask
	task automatic t_break();
		wr(dbg_regs_pkg::OFS_INSTR_BREAK_ADDRESS, 32'h0000BEEF);
		for (int i = 1; i < 4; i++) begin
			wr(dbg_regs_pkg::OFS_INSTR_BREAK_ADDRESS + 8'(i), 32'h00004000);
			wr(dbg_regs_pkg::OFS_IBREAK_CTRL + 8'(i),
				(i == 3) ? 32'h00100001 : 32'h00080001);
		end
		@(posedge sys_clk);
		pc_valid <= 1'b1;
		issue_pc <= 32'h00004000;
		issue_thread <= 8'h03;
		@(negedge sys_clk);
		chk({29'h0, ibreak_hit, ibreak_index}, 32'h5);
		wr(dbg_regs_pkg::OFS_IBREAK_CTRL, 32'h00080003);
		@(negedge sys_clk);
		chk({29'h0, ibreak_hit, ibreak_index}, 32'h4);
		@(posedge sys_clk);
		issue_thread <= 8'h04;
		@(negedge sys_clk);
		chk({29'h0, ibreak_hit, ibreak_index}, 32'h7);
		@(posedge sys_clk);
		in_debug_mode <= 1'b1;
		@(negedge sys_clk);
		chk({31'h0, ibreak_hit}, 32'h0);
		@(posedge sys_clk);
		in_debug_mode <= 1'b0;
		pc_valid <= 1'b0;
		@(negedge sys_clk);
		chk({31'h0, ibreak_hit}, 32'h0);
		@(posedge sys_clk);
		pc_valid <= 1'b1;
		issue_thread <= 8'h05;
		@(negedge sys_clk);
		chk({31'h0, ibreak_hit}, 32'h0);
		@(posedge sys_clk);
		pc_valid <= 1'b0;
	endtask
	task automatic test_done();
		if (miscompares == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		rst_n = 1'b0;
		ps_req = '0;
		entry = '0;
		issue_mode_bit = 1'b0;
		pc_valid = 1'b0;
		issue_pc = 32'h0;
		issue_thread = 8'h0;
		in_debug_mode = 1'b0;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset();
		t_capture();
		t_regs();
		t_scratch();
		t_break();
		test_done();
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		miscompares++;
		test_done();
	end
endmodule // test_debug_state_capture_regs
